// ---- rtl/assfc_consts.vh ----
`ifndef ASSFC_CONSTS_VH
`define ASSFC_CONSTS_VH
// Byte addresses on the register bus
`define ASSFC_ADDR_STATUS 5'h00
`define ASSFC_ADDR_DATA 5'h04
`define ASSFC_ADDR_CFG 5'h08
`define ASSFC_ADDR_CTRL2 5'h0C
`define ASSFC_ADDR_BAUD 5'h10
// Status bit positions
`define ASSFC_ST_TXE 7
`define ASSFC_ST_TXD 6
`define ASSFC_ST_RXF 5
`define ASSFC_ST_IDLE 4
`define ASSFC_ST_OVR 3
`define ASSFC_ST_NOISE 2
`define ASSFC_ST_FRM 1
`define ASSFC_ST_PAR 0
`define ASSFC_STATUS_RST 8'hC0
// Frame config bit positions
`define ASSFC_CF_RX9 7
`define ASSFC_CF_TX9 6
`define ASSFC_CF_LPD 5
`define ASSFC_CF_LEN9 4
`define ASSFC_CF_WAKE 3
`define ASSFC_CF_PEN 2
`define ASSFC_CF_PODD 1
`define ASSFC_CF_PIE 0
// Control two bit positions
`define ASSFC_C2_TIE 7
`define ASSFC_C2_TX_DONE_IRQ_EN 6
`define ASSFC_C2_RIE 5
`define ASSFC_C2_QUIET_LINE_IRQ_EN 4
`define ASSFC_C2_TE 3
`define ASSFC_C2_RE 2
`define ASSFC_C2_MUTE 1
`define ASSFC_C2_BRK 0
// Oversampling
`define ASSFC_OVS 4'hF
`define ASSFC_BAUD_RST 16'h006C
`define ASSFC_RESP_OK 2'h0
`define ASSFC_RESP_ERR 2'h2
`endif

// ---- rtl/assfc_top.v ----
// What this block does
// - Wait leaves serial running; enabled events wake
// - Halt suspends serial; events never wake halt
// - One shared request, each event gated
// - Tx-empty set on load; cleared status-then-write
// - No shift load while tx-empty set
// - Tx-done set after data frame; same clear
// - Idle or break frames leave tx-done
// - Rx-full set on word; status-then-read clears
// - Idle flag once per rx-full; read clears
// - Overrun keeps holding word, flags, interrupts
// - Noise flag, no interrupt, read clears
// - Framing flag; overrun suppresses it same word
// - Parity flag, gated interrupt, status-read arms
// - Status resets to tx-empty, tx-done set
// - Ninth bits live in config 7/6
// - Low-power bit stops prescaler after byte
// - Length bit picks 8 or 9 data
// - Wake bit picks idle or address mark
// - Parity replaces top data bit, checked
// - Parity odd select, applies after byte
// - Parity interrupt enable gates parity interrupt
// - Sixteen samples, majority 8/9/10, noise
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "assfc_consts.vh"
module assfc_top (
  input wire sys_clk,
  input wire rst_n,
  input wire cpu_wait,
  input wire cpu_halt,
  output wire wake_req,
  output wire irq,
  input wire rx_line,
  output reg tx_line,
  output reg tx_oe,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  reg [7:0] status;
  reg [7:0] cfg;
  reg [7:0] ctrl2;
  reg [15:0] baud_div;
  reg [7:0] tx_hold;
  reg [7:0] rx_hold;
  reg armed;
  reg armed_by_read;
  reg idle_allowed;
  // AXI write side
  reg aw_got, w_got;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg w_lane0;
  reg w_lane1;
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  wire [4:0] wa = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : aw_addr;
  wire [31:0] wd = s_axi_wvalid && s_axi_wready ? s_axi_wdata : w_data;
  wire wl = s_axi_wvalid && s_axi_wready ? s_axi_wstrb[0] : w_lane0;
  // Upper lane is latched too, since W may arrive before AW
  wire wl1 = s_axi_wvalid && s_axi_wready ? s_axi_wstrb[1] : w_lane1;
  wire wr_go = (aw_got || (s_axi_awvalid && s_axi_awready)) &&
               (w_got || (s_axi_wvalid && s_axi_wready));
  wire wr_map = wa == `ASSFC_ADDR_STATUS || wa == `ASSFC_ADDR_DATA ||
                wa == `ASSFC_ADDR_CFG || wa == `ASSFC_ADDR_CTRL2 ||
                wa == `ASSFC_ADDR_BAUD;
  wire wr_en = wr_go && wl;
  wire wr_data = wr_en && wa == `ASSFC_ADDR_DATA;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire rd_data = rd_go && s_axi_araddr == `ASSFC_ADDR_DATA;
  wire rd_stat = rd_go && s_axi_araddr == `ASSFC_ADDR_STATUS;
  wire wr_stat = wr_go && wa == `ASSFC_ADDR_STATUS;
  // Data access after a status access clears the relevant flags
  wire clr_tx = armed && wr_data;
  wire clr_rx = armed && rd_data;
  wire clr_par = armed_by_read && (rd_data || wr_data);
  // Baud tick: 16x oversampling, frozen in halt or low-power idle
  reg [15:0] pre_cnt;
  reg tx_busy, rx_busy;
  wire lp_stop = cfg[`ASSFC_CF_LPD] && !tx_busy && !rx_busy;
  wire run = !cpu_halt && !lp_stop;
  wire tick = run && pre_cnt == 16'h0000;
  always @(posedge sys_clk) begin
    if (!rst_n)
      pre_cnt <= 16'h0000;
    else if (run)
      pre_cnt <= (pre_cnt == 16'h0000) ? baud_div : pre_cnt - 16'h0001;
  end
  // Transmitter
  reg [3:0] tx_os;
  reg [3:0] tx_bit;
  reg [10:0] tx_shift;
  reg tx_kind_data;
  reg tx_len9;
  reg te_q;
  reg brk_q;
  reg pend_idle, pend_brk;
  wire te = ctrl2[`ASSFC_C2_TE];
  wire brk = ctrl2[`ASSFC_C2_BRK];
  wire [7:0] cd = tx_hold;
  wire p8 = ^cd[6:0] ^ cfg[`ASSFC_CF_PODD];
  wire p9 = ^cd[7:0] ^ cfg[`ASSFC_CF_PODD];
  wire len9 = cfg[`ASSFC_CF_LEN9];
  // Parity replaces the top data bit; config is sampled at frame start
  wire [8:0] tx_word = len9 ?
    {cfg[`ASSFC_CF_PEN] ? p9 : cfg[`ASSFC_CF_TX9], cd} :
    {1'b1, cfg[`ASSFC_CF_PEN] ? p8 : cd[7], cd[6:0]};
  wire tx_last = tx_bit == (tx_len9 ? 4'hA : 4'h9);
  wire tx_load = te && !tx_busy && tick && !status[`ASSFC_ST_TXE] &&
                 !pend_idle && !pend_brk;
  wire tx_end = tx_busy && tick && tx_os == `ASSFC_OVS && tx_last;
  wire tx_done_set = tx_end && tx_kind_data;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_os <= 4'h0;
      tx_bit <= 4'h0;
      tx_shift <= 11'h7FF;
      tx_kind_data <= 1'b0;
      tx_len9 <= 1'b0;
      tx_line <= 1'b1;
      tx_oe <= 1'b0;
      te_q <= 1'b0;
      brk_q <= 1'b0;
      pend_idle <= 1'b0;
      pend_brk <= 1'b0;
    end else begin
      te_q <= te;
      brk_q <= brk;
      if (te && !te_q && tx_busy)
        pend_idle <= 1'b1;
      if (!brk && brk_q)
        pend_brk <= 1'b1;
      tx_oe <= (te || ctrl2[`ASSFC_C2_RE]) && !lp_stop;
      if (tx_load) begin
        tx_busy <= 1'b1;
        tx_kind_data <= 1'b1;
        tx_len9 <= len9;
        tx_shift <= {1'b1, tx_word, 1'b0};
        tx_os <= 4'h0;
        tx_bit <= 4'h0;
      end else if (te && !tx_busy && tick && (pend_idle || pend_brk || brk)) begin
        tx_busy <= 1'b1;
        tx_kind_data <= 1'b0;
        tx_len9 <= len9;
        tx_shift <= (pend_brk || brk) ? 11'h000 : 11'h7FF;
        tx_os <= 4'h0;
        tx_bit <= 4'h0;
        pend_idle <= 1'b0;
        pend_brk <= 1'b0;
      end else if (tx_busy && tick) begin
        tx_os <= tx_os + 4'h1;
        if (tx_os == `ASSFC_OVS) begin
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_bit <= tx_bit + 4'h1;
          if (tx_last)
            tx_busy <= 1'b0;
        end
      end
      tx_line <= tx_busy ? tx_shift[0] : 1'b1;
    end
  end
  // Receiver with 16x sampling and 8/9/10 majority
  reg [3:0] rx_os;
  reg [3:0] rx_bit;
  reg [9:0] rx_shift;
  reg [1:0] smp;
  reg rx_noise;
  reg rx_len9, rx_pen, rx_podd;
  reg [3:0] idle_cnt;
  reg rx_line_q;
  wire re = ctrl2[`ASSFC_C2_RE];
  wire mute = ctrl2[`ASSFC_C2_MUTE];
  wire maj = (smp[0] & smp[1]) | (smp[1] & rx_line) | (smp[0] & rx_line);
  wire disagree = !(smp[0] == smp[1] && smp[1] == rx_line);
  wire rx_last = rx_bit == (rx_len9 ? 4'hA : 4'h9);
  wire rx_end = rx_busy && tick && rx_os == 4'h9 && rx_last;
  wire [9:0] rx_full = {maj, rx_shift[9:1]};
  // Stop bit sits in bit 9; in nine-bit mode the start bit has already dropped out
  wire [8:0] rx_word = rx_len9 ? rx_full[8:0] : {1'b0, rx_full[8:1]};
  wire rx_msb = rx_len9 ? rx_word[8] : rx_word[7];
  wire rx_par_bad = rx_pen &&
    ((rx_len9 ? ^rx_word[8:0] : ^rx_word[7:0]) != rx_podd);
  wire rx_frm_bad = !maj;
  wire addr_wake = mute && cfg[`ASSFC_CF_WAKE] && rx_msb;
  wire rx_take = rx_end && (!mute || addr_wake);
  wire ovr = rx_take && status[`ASSFC_ST_RXF] && !clr_rx;
  wire rx_move = rx_take && !ovr;
  wire idle_det = re && !rx_busy && tick && idle_cnt == 4'hA && rx_os == `ASSFC_OVS;
  wire idle_wake = idle_det && mute && !cfg[`ASSFC_CF_WAKE];
  wire idle_set = idle_det && !mute && idle_allowed;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_os <= 4'h0;
      rx_bit <= 4'h0;
      rx_shift <= 10'h000;
      smp <= 2'h3;
      rx_noise <= 1'b0;
      rx_len9 <= 1'b0;
      rx_pen <= 1'b0;
      rx_podd <= 1'b0;
      idle_cnt <= 4'h0;
      rx_line_q <= 1'b1;
    end else if (tick) begin
      rx_line_q <= rx_line;
      if (!re) begin
        rx_busy <= 1'b0;
        idle_cnt <= 4'h0;
        rx_os <= 4'h0;
      end else if (!rx_busy) begin
        rx_os <= rx_os + 4'h1;
        if (rx_os == `ASSFC_OVS)
          idle_cnt <= (idle_cnt == 4'hA) ? idle_cnt : idle_cnt + 4'h1;
        if (rx_line_q && !rx_line) begin
          rx_busy <= 1'b1;
          rx_os <= 4'h1;
          rx_bit <= 4'h0;
          rx_noise <= 1'b0;
          rx_len9 <= len9;
          rx_pen <= cfg[`ASSFC_CF_PEN];
          rx_podd <= cfg[`ASSFC_CF_PODD];
        end else if (!rx_line)
          idle_cnt <= 4'h0;
      end else begin
        rx_os <= rx_os + 4'h1;
        if (rx_os == 4'h7)
          smp[0] <= rx_line;
        if (rx_os == 4'h8)
          smp[1] <= rx_line;
        if (rx_os == 4'h9) begin
          if (disagree)
            rx_noise <= 1'b1;
          rx_shift <= rx_full;
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == 4'h0 && maj)
            rx_busy <= 1'b0;
          if (rx_last) begin
            rx_busy <= 1'b0;
            idle_cnt <= 4'h0;
          end
        end
      end
    end
  end
  // Status flags: hardware set wins over the software clear
  wire txe_set = tx_load;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      status <= `ASSFC_STATUS_RST;
      armed <= 1'b0;
      armed_by_read <= 1'b0;
      idle_allowed <= 1'b1;
      rx_hold <= 8'h00;
      tx_hold <= 8'h00;
      cfg <= 8'h00;
      ctrl2 <= 8'h00;
      baud_div <= `ASSFC_BAUD_RST;
    end else begin
      if (rd_stat || wr_stat)
        armed <= 1'b1;
      else if (rd_data || wr_data)
        armed <= 1'b0;
      if (rd_stat)
        armed_by_read <= 1'b1;
      else if (rd_data || wr_data)
        armed_by_read <= 1'b0;
      status[`ASSFC_ST_TXE] <= txe_set | (status[`ASSFC_ST_TXE] & ~clr_tx);
      status[`ASSFC_ST_TXD] <= tx_done_set | (status[`ASSFC_ST_TXD] & ~clr_tx);
      status[`ASSFC_ST_RXF] <= rx_move | (status[`ASSFC_ST_RXF] & ~clr_rx);
      status[`ASSFC_ST_IDLE] <= idle_set | (status[`ASSFC_ST_IDLE] & ~clr_rx);
      status[`ASSFC_ST_OVR] <= ovr | (status[`ASSFC_ST_OVR] & ~clr_rx);
      status[`ASSFC_ST_NOISE] <= (rx_take && (rx_noise || disagree)) |
                                 (status[`ASSFC_ST_NOISE] & ~clr_rx);
      status[`ASSFC_ST_FRM] <= (rx_take && rx_frm_bad && !ovr) |
                               (status[`ASSFC_ST_FRM] & ~clr_rx);
      status[`ASSFC_ST_PAR] <= (rx_move && rx_par_bad) |
                               (status[`ASSFC_ST_PAR] & ~clr_par);
      if (idle_set)
        idle_allowed <= 1'b0;
      else if (rx_move)
        idle_allowed <= 1'b1;
      if (rx_move) begin
        rx_hold <= rx_word[7:0];
        cfg[`ASSFC_CF_RX9] <= rx_word[8];
      end
      if (wr_data)
        tx_hold <= wd[7:0];
      if (wr_en && wa == `ASSFC_ADDR_CFG)
        cfg[6:0] <= wd[6:0];
      if (wr_en && wa == `ASSFC_ADDR_CTRL2)
        ctrl2 <= wd[7:0];
      else if (idle_wake || (rx_end && addr_wake))
        ctrl2[`ASSFC_C2_MUTE] <= 1'b0;
      if (wr_en && wa == `ASSFC_ADDR_BAUD)
        baud_div <= {wl1 ? wd[15:8] : baud_div[15:8], wd[7:0]};
    end
  end
  // Shared request; never a halt wake source
  wire any_irq = (status[`ASSFC_ST_TXE] && ctrl2[`ASSFC_C2_TIE]) ||
                 (status[`ASSFC_ST_TXD] && ctrl2[`ASSFC_C2_TX_DONE_IRQ_EN]) ||
                 ((status[`ASSFC_ST_RXF] || status[`ASSFC_ST_OVR]) && ctrl2[`ASSFC_C2_RIE]) ||
                 (status[`ASSFC_ST_IDLE] && ctrl2[`ASSFC_C2_QUIET_LINE_IRQ_EN]) ||
                 (status[`ASSFC_ST_PAR] && cfg[`ASSFC_CF_PIE]);
  assign irq = any_irq;
  assign wake_req = any_irq && cpu_wait && !cpu_halt;
  // AXI handshake bookkeeping and read mux
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
      w_lane1 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ASSFC_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ASSFC_RESP_OK;
    end else begin
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_map && wa != `ASSFC_ADDR_STATUS) ? `ASSFC_RESP_OK : `ASSFC_RESP_ERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_got <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_got <= 1'b1;
          w_data <= s_axi_wdata;
          w_lane0 <= s_axi_wstrb[0];
          w_lane1 <= s_axi_wstrb[1];
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ASSFC_RESP_OK;
        case (s_axi_araddr)
          `ASSFC_ADDR_STATUS: s_axi_rdata <= {24'h000000, status};
          `ASSFC_ADDR_DATA: s_axi_rdata <= {24'h000000, rx_hold};
          `ASSFC_ADDR_CFG: s_axi_rdata <= {24'h000000, cfg};
          `ASSFC_ADDR_CTRL2: s_axi_rdata <= {24'h000000, ctrl2};
          `ASSFC_ADDR_BAUD: s_axi_rdata <= {16'h0000, baud_div};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ASSFC_RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // assfc_top

// ---- testbench/assfc_asserts.sv ----
`timescale 1ns/1ps
module assfc_asserts (
  input wire sys_clk,
  input wire rst_n,
  input wire cpu_wait,
  input wire cpu_halt,
  input wire wake_req,
  input wire irq,
  input wire tx_line,
  input wire tx_oe,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Loose on purpose: a slower divider only lengthens the bit
  sequence s_start_bit;
    (!tx_line)[*8] ##1 (!tx_line)[*7];
  endsequence
  property p_wake;
    wake_req == (irq && cpu_wait && !cpu_halt);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request wrong");
  property p_halt_nowake;
    cpu_halt |-> !wake_req;
  endproperty
  a_halt_nowake: assert property (p_halt_nowake)
    else $error("wake during halt");
  property p_halt_freeze;
    // A shift from the tick just before halt still shows on the pin for one cycle
    cpu_halt [*3] |-> $stable(tx_line);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("serial output moved in halt");
  property p_irq_reset;
    $rose(rst_n) |-> !irq;
  endproperty
  a_irq_reset: assert property (p_irq_reset)
    else $error("request without enable");
  property p_quiet_out;
    !tx_oe |-> tx_line;
  endproperty
  a_quiet_out: assert property (p_quiet_out)
    else $error("stopped output not idle");
  property p_start;
    $fell(tx_line) |-> s_start_bit;
  endproperty
  a_start: assert property (p_start)
    else $error("start bit too short");
  property p_wr_answer;
    s_wr_take |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data late");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("second read taken");
endmodule // assfc_asserts
bind assfc_top assfc_asserts assfc_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .cpu_wait(cpu_wait), .cpu_halt(cpu_halt), .wake_req(wake_req), .irq(irq),
  .tx_line(tx_line), .tx_oe(tx_oe), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ---- testbench/assfc_peer.sv ----
`timescale 1ns/1ps
module assfc_peer (
  input wire sys_clk,
  input wire tx_line,
  input wire len9,
  output reg rx_line
);
  logic [8:0] got = 9'h000;
  int got_n = 0;
  initial rx_line = 1'b1;
  // One clock per tick, so a bit lasts 16 clocks; glitch hits the last of the three votes
  task automatic send(input logic [8:0] d, input int n, input logic stp, input logic glitch);
    rx_line <= 1'b0;
    repeat (16) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      rx_line <= d[i];
      repeat (9) @(posedge sys_clk);
      if (glitch && i == 0) rx_line <= !d[i];
      @(posedge sys_clk);
      rx_line <= d[i];
      repeat (6) @(posedge sys_clk);
    end
    rx_line <= stp;
    repeat (16) @(posedge sys_clk);
    rx_line <= 1'b1;
    repeat (16) @(posedge sys_clk);
  endtask
  always begin : rx_side
    logic [8:0] w;
    @(negedge tx_line);
    repeat (8) @(posedge sys_clk);
    w = 9'h000;
    for (int i = 0; i < (len9 ? 9 : 8); i++) begin
      repeat (16) @(posedge sys_clk);
      w[i] = tx_line;
    end
    repeat (16) @(posedge sys_clk);
    got = w;
    got_n++;
  end
endmodule // assfc_peer

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`include "assfc_consts.vh"
module tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, cpu_wait = 1'b0, cpu_halt = 1'b0, len9 = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire wake_req, irq, rx_line, tx_line, tx_oe;
  int bad_count = 0, tests_run = 0;
  localparam logic [1:0] OK = `ASSFC_RESP_OK, ER = `ASSFC_RESP_ERR;
  localparam logic [4:0] ST = `ASSFC_ADDR_STATUS, DR = `ASSFC_ADDR_DATA;
  localparam logic [4:0] CF = `ASSFC_ADDR_CFG, C2 = `ASSFC_ADDR_CTRL2, BD = `ASSFC_ADDR_BAUD;
  always #2.5 sys_clk = ~sys_clk;
  // Responses are always accepted at once, so bready and rready stay high
  assfc_top assfc_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_wait(cpu_wait),
    .cpu_halt(cpu_halt), .wake_req(wake_req), .irq(irq), .rx_line(rx_line),
    .tx_line(tx_line), .tx_oe(tx_oe), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1));
  assfc_peer assfc_peer_inst (.sys_clk(sys_clk), .tx_line(tx_line), .len9(len9),
    .rx_line(rx_line));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        check(s_axi_bresp, r);
        break;
      end
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        check(s_axi_rdata, e);
        check(s_axi_rresp, r);
        break;
      end
    end
  endtask
  task automatic tx_word(input logic [7:0] d);
    int n;
    n = assfc_peer_inst.got_n;
    rd(ST, 32'hC0, OK);
    wr(DR, {24'h0, d}, OK);
    while (assfc_peer_inst.got_n == n) @(posedge sys_clk);
    // The peer is done before the stop bit ends; config stays put until then
    repeat (30) @(posedge sys_clk);
  endtask
  task automatic t_end(input string s);
    $display("test %s finished", s);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ST, 32'hC0, OK);
    rd(5'h14, 32'h0, ER);
    wr(5'h14, 32'hFF, ER);
    wr(ST, 32'h0, ER);
    rd(ST, 32'hC0, OK);
    t_end("reset");
    wr(BD, 32'h0, OK);
    wr(C2, 32'h88, OK);
    @(negedge sys_clk);
    check(irq, 1'b1);
    check(tx_oe, 1'b1);
    @(posedge sys_clk);
    tx_word(8'hA5);
    check(assfc_peer_inst.got, 9'h0A5);
    rd(ST, 32'hC0, OK);
    len9 <= 1'b1;
    wr(CF, 32'h50, OK);
    tx_word(8'h3C);
    check(assfc_peer_inst.got, 9'h13C);
    len9 <= 1'b0;
    wr(CF, 32'h0, OK);
    t_end("transmit");
    wr(C2, 32'h2C, OK);
    assfc_peer_inst.send(9'h03C, 8, 1'b1, 1'b0);
    @(negedge sys_clk);
    check(irq, 1'b1);
    repeat (200) @(posedge sys_clk);
    rd(DR, 32'h3C, OK);
    rd(ST, 32'hF0, OK);
    rd(DR, 32'h3C, OK);
    rd(ST, 32'hC0, OK);
    repeat (200) @(posedge sys_clk);
    rd(ST, 32'hC0, OK);
    assfc_peer_inst.send(9'h011, 8, 1'b1, 1'b0);
    assfc_peer_inst.send(9'h022, 8, 1'b0, 1'b0);
    repeat (200) @(posedge sys_clk);
    rd(ST, 32'hF8, OK);
    rd(DR, 32'h11, OK);
    rd(ST, 32'hC0, OK);
    t_end("receive");
    wr(C2, 32'h0C, OK);
    wr(CF, 32'h06, OK);
    assfc_peer_inst.send(9'h001, 8, 1'b1, 1'b0);
    repeat (200) @(posedge sys_clk);
    rd(ST, 32'hF0, OK);
    rd(DR, 32'h01, OK);
    wr(CF, 32'h05, OK);
    assfc_peer_inst.send(9'h001, 8, 1'b1, 1'b1);
    repeat (200) @(posedge sys_clk);
    @(negedge sys_clk);
    check(irq, 1'b1);
    @(posedge sys_clk);
    rd(ST, 32'hF5, OK);
    wr(CF, 32'h04, OK);
    @(negedge sys_clk);
    check(irq, 1'b0);
    @(posedge sys_clk);
    rd(DR, 32'h01, OK);
    rd(ST, 32'hC0, OK);
    t_end("parity");
    wr(CF, 32'h08, OK);
    wr(C2, 32'h0E, OK);
    assfc_peer_inst.send(9'h022, 8, 1'b1, 1'b0);
    rd(ST, 32'hC0, OK);
    assfc_peer_inst.send(9'h0A2, 8, 1'b1, 1'b0);
    repeat (200) @(posedge sys_clk);
    rd(C2, 32'h0C, OK);
    rd(ST, 32'hF0, OK);
    rd(DR, 32'hA2, OK);
    t_end("mute");
    wr(C2, 32'h08, OK);
    wr(CF, 32'h0, OK);
    rd(ST, 32'hC0, OK);
    wr(DR, 32'h55, OK);
    repeat (40) @(posedge sys_clk);
    cpu_halt <= 1'b1;
    repeat (60) @(posedge sys_clk);
    rd(ST, 32'h80, OK);
    cpu_halt <= 1'b0;
    repeat (300) @(posedge sys_clk);
    rd(ST, 32'hC0, OK);
    wr(C2, 32'h88, OK);
    cpu_wait <= 1'b1;
    @(negedge sys_clk);
    check(wake_req, 1'b1);
    @(posedge sys_clk);
    cpu_halt <= 1'b1;
    @(negedge sys_clk);
    check(wake_req, 1'b0);
    @(posedge sys_clk);
    cpu_halt <= 1'b0;
    cpu_wait <= 1'b0;
    wr(CF, 32'h20, OK);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    check(tx_oe, 1'b0);
    t_end("power");
    test_done();
  end
endmodule // tb_top
